// >>> core/acs_defines.vh
// acs_defines.vh: register offsets, field positions, reset values and timing figures
// assumes a 125 MHz core clock; included by the sequencer and its value store
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH

// register offsets
`define ACS_ADDR_CFG6        8'h10
`define ACS_ADDR_VALUE_BASE  8'h20
`define ACS_ADDR_VALUE_LAST  8'h27
`define ACS_ADDR_FAN1_SEL    8'h55
`define ACS_ADDR_CFG2        8'h73
`define ACS_ADDR_CFG4        8'h7D

// reset values
`define ACS_RST_CFG          8'h00
`define ACS_RST_VALUE        10'h000

// field positions
`define ACS_CFG2_AVG_OFF     4
`define ACS_CFG2_BYPASS_ALL  5
`define ACS_CFG2_SINGLE      6
`define ACS_CFG6_SLOW_CYCLE  7
`define ACS_CFG4_BYP_2V5     4
`define ACS_CFG4_BYP_CORE    5
`define ACS_CFG4_BYP_5V      6
`define ACS_CFG4_BYP_12V     7
`define ACS_SEL_MSB          7
`define ACS_SEL_LSB          5

// channel codes
`define ACS_CH_2V5           3'h0
`define ACS_CH_CORE          3'h1
`define ACS_CH_OWN           3'h2
`define ACS_CH_5V            3'h3
`define ACS_CH_12V           3'h4
`define ACS_CH_REMOTE1       3'h5
`define ACS_CH_LOCAL         3'h6
`define ACS_CH_REMOTE2       3'h7

// averaging and code range
`define ACS_AVG_COUNT        16
`define ACS_AVG_SHIFT        4
`define ACS_CODE_MAX         10'h03FF
`define ACS_CODE_NOMINAL     10'h0300

// times in microseconds, clock rate in MHz
`define ACS_CLK_MHZ          125
`define ACS_VOLT_TIME_US     700
`define ACS_REMOTE_TIME_US   7000
`define ACS_LOCAL_TIME_US    1300
`define ACS_CYCLE_DEF_US     146500
`define ACS_CYCLE_SLOW_US    240000

`endif

// >>> core/acs_value_mem.v
// acs_value_mem.v: eight 10-bit channel results with a registered read port
// assumes one clock, async active-low reset; one write and one read per cycle
`timescale 1ns/1ps
`include "acs_defines.vh"

module acs_value_mem (
  // clock and reset
  input  wire       clock_i,
  input  wire       rst_n_i,
  // write port
  input  wire       wr_en_i,
  input  wire [2:0] wr_addr_i,
  input  wire [9:0] wr_data_i,
  // read port
  input  wire [2:0] rd_addr_i,
  output reg  [9:0] rd_data_o
);

  reg [9:0] mem_q [0:7];
  integer   i;

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < 8; i = i + 1) begin
        mem_q[i] <= `ACS_RST_VALUE;
      end
      rd_data_o <= `ACS_RST_VALUE;
    end else begin
      if (wr_en_i) begin
        mem_q[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem_q[rd_addr_i];
    end
  end

endmodule

// >>> core/acs_sequencer.v
// acs_sequencer.v: round-robin and single-channel conversion sequencer with averaging
// assumes the converter runs on clock_i and returns one raw code with each done pulse
`timescale 1ns/1ps
`include "acs_defines.vh"

module acs_sequencer #(
  parameter integer VOLT_CYC   = `ACS_VOLT_TIME_US * `ACS_CLK_MHZ,
  parameter integer REMOTE_CYC = `ACS_REMOTE_TIME_US * `ACS_CLK_MHZ,
  parameter integer LOCAL_CYC  = `ACS_LOCAL_TIME_US * `ACS_CLK_MHZ,
  parameter integer CYCLE_DEF  = `ACS_CYCLE_DEF_US * `ACS_CLK_MHZ,
  parameter integer CYCLE_SLOW = `ACS_CYCLE_SLOW_US * `ACS_CLK_MHZ
) (
  // clock and reset
  input  wire        clock_i,
  input  wire        rst_n_i,
  // register port
  input  wire [7:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_rdata_o,
  output reg         reg_rvalid_o,
  // converter
  output reg  [2:0]  adc_channel_o,
  output wire        adc_start_o,
  output reg  [4:0]  atten_bypass_o,
  input  wire        adc_done_i,
  input  wire [11:0] adc_raw_i,
  // fan limit share
  output wire [7:0]  first_fan_tachometer_min_high_o
);

  localparam [1:0] ST_CONV = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;

  // last-cycle counts, cut to counter widths where used
  localparam [31:0] VOLT_LAST_W   = VOLT_CYC - 1;
  localparam [31:0] REMOTE_LAST_W = REMOTE_CYC - 1;
  localparam [31:0] LOCAL_LAST_W  = LOCAL_CYC - 1;
  localparam [31:0] DEF_LAST_W    = CYCLE_DEF - 1;
  localparam [31:0] SLOW_LAST_W   = CYCLE_SLOW - 1;
  localparam [31:0] AVG_LAST_W    = `ACS_AVG_COUNT - 1;

  // configuration registers
  reg [7:0] cfg6_q;
  reg [7:0] cfg2_q;
  reg [7:0] cfg4_q;
  reg [7:0] fan1_sel_q;

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg6_q     <= `ACS_RST_CFG;
      cfg2_q     <= `ACS_RST_CFG;
      cfg4_q     <= `ACS_RST_CFG;
      fan1_sel_q <= `ACS_RST_CFG;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `ACS_ADDR_CFG6:     cfg6_q     <= reg_wdata_i;
        `ACS_ADDR_CFG2:     cfg2_q     <= reg_wdata_i;
        `ACS_ADDR_CFG4:     cfg4_q     <= reg_wdata_i;
        `ACS_ADDR_FAN1_SEL: fan1_sel_q <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  assign first_fan_tachometer_min_high_o = fan1_sel_q;

  wire       avg_off  = cfg2_q[`ACS_CFG2_AVG_OFF];
  wire       single   = cfg2_q[`ACS_CFG2_SINGLE];
  wire       byp_all  = cfg2_q[`ACS_CFG2_BYPASS_ALL];
  wire [2:0] sel_ch   = fan1_sel_q[`ACS_SEL_MSB:`ACS_SEL_LSB];

  // attenuator controls; with attenuators in, nominal rail reads 3/4 scale
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      atten_bypass_o <= 5'h00;
    end else begin
      atten_bypass_o[`ACS_CH_2V5]  <= byp_all | cfg4_q[`ACS_CFG4_BYP_2V5];
      atten_bypass_o[`ACS_CH_CORE] <= byp_all | cfg4_q[`ACS_CFG4_BYP_CORE];
      atten_bypass_o[`ACS_CH_OWN]  <= byp_all;
      atten_bypass_o[`ACS_CH_5V]   <= byp_all | cfg4_q[`ACS_CFG4_BYP_5V];
      atten_bypass_o[`ACS_CH_12V]  <= byp_all | cfg4_q[`ACS_CFG4_BYP_12V];
    end
  end

  // raw code saturation
  reg [9:0] code_sat;
  always @* begin
    if (adc_raw_i[11]) begin
      code_sat = 10'h000;
    end else if (adc_raw_i[10]) begin
      code_sat = `ACS_CODE_MAX;
    end else begin
      code_sat = adc_raw_i[9:0];
    end
  end

  // sequencing state
  reg [1:0]  state_q;
  reg [19:0] slot_cnt_q;
  reg [24:0] cyc_cnt_q;
  reg [3:0]  conv_n_q;
  reg [13:0] acc_q;

  wire [13:0] acc_sum = acc_q + (adc_done_i ? {4'h0, code_sat} : 14'h0000);

  reg [19:0] slot_last;
  always @* begin
    if (single) begin
      slot_last = VOLT_LAST_W[19:0];
    end else begin
      case (adc_channel_o)
        `ACS_CH_REMOTE1: slot_last = REMOTE_LAST_W[19:0];
        `ACS_CH_REMOTE2: slot_last = REMOTE_LAST_W[19:0];
        `ACS_CH_LOCAL:   slot_last = LOCAL_LAST_W[19:0];
        default:         slot_last = VOLT_LAST_W[19:0];
      endcase
    end
  end

  wire [24:0] cycle_last = cfg6_q[`ACS_CFG6_SLOW_CYCLE] ? SLOW_LAST_W[24:0] : DEF_LAST_W[24:0];
  wire [3:0]  conv_last  = avg_off ? 4'h0 : AVG_LAST_W[3:0];
  // at or past the end: a shorter slot chosen mid-slot still ends it
  wire        slot_end   = (state_q == ST_CONV) && (slot_cnt_q >= slot_last);
  wire        result_end = slot_end && (conv_n_q >= conv_last);
  wire [9:0]  result     = avg_off ? acc_sum[9:0] : acc_sum[13:`ACS_AVG_SHIFT];

  assign adc_start_o = (state_q == ST_CONV) && (slot_cnt_q == 20'h0_0000);

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q       <= ST_CONV;
      slot_cnt_q    <= 20'h0_0000;
      cyc_cnt_q     <= 25'h000_0000;
      conv_n_q      <= 4'h0;
      acc_q         <= 14'h0000;
      adc_channel_o <= `ACS_CH_2V5;
    end else begin
      cyc_cnt_q <= (cyc_cnt_q == 25'h1FF_FFFF) ? cyc_cnt_q : cyc_cnt_q + 25'h000_0001;
      case (state_q)
        ST_CONV: begin
          if (!slot_end) begin
            slot_cnt_q <= slot_cnt_q + 20'h0_0001;
            acc_q      <= acc_sum;
          end else begin
            slot_cnt_q <= 20'h0_0000;
            if (single && adc_channel_o != sel_ch) begin
              // selector moved: drop partial average, restart on new channel
              conv_n_q      <= 4'h0;
              acc_q         <= 14'h0000;
              adc_channel_o <= sel_ch;
            end else if (!result_end) begin
              conv_n_q <= conv_n_q + 4'h1;
              acc_q    <= acc_sum;
            end else begin
              conv_n_q <= 4'h0;
              acc_q    <= 14'h0000;
              if (single) begin
                adc_channel_o <= sel_ch;
              end else if (adc_channel_o == `ACS_CH_REMOTE2) begin
                state_q <= ST_WAIT;
              end else begin
                adc_channel_o <= adc_channel_o + 3'h1;
              end
            end
          end
        end
        ST_WAIT: begin
          if (single) begin
            state_q       <= ST_CONV;
            adc_channel_o <= sel_ch;
          end else if (cyc_cnt_q >= cycle_last) begin
            // pass start; an overlong pass restarts at once
            state_q       <= ST_CONV;
            cyc_cnt_q     <= 25'h000_0000;
            adc_channel_o <= `ACS_CH_2V5;
          end
        end
        default: begin
          state_q <= ST_CONV;
        end
      endcase
    end
  end

  // value store and register reads
  wire [9:0] mem_rdata;
  acs_value_mem u_mem (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (result_end),
    .wr_addr_i (adc_channel_o),
    .wr_data_i (result),
    .rd_addr_i (reg_addr_i[2:0]),
    .rd_data_o (mem_rdata)
  );

  reg       rd_q;
  reg       rd_mem_q;
  reg [7:0] rd_cfg_q;

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_q         <= 1'b0;
      rd_mem_q     <= 1'b0;
      rd_cfg_q     <= 8'h00;
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      rd_q     <= reg_rd_i;
      rd_mem_q <= (reg_addr_i >= `ACS_ADDR_VALUE_BASE) && (reg_addr_i <= `ACS_ADDR_VALUE_LAST);
      case (reg_addr_i)
        `ACS_ADDR_CFG6:     rd_cfg_q <= cfg6_q;
        `ACS_ADDR_CFG2:     rd_cfg_q <= cfg2_q;
        `ACS_ADDR_CFG4:     rd_cfg_q <= cfg4_q;
        `ACS_ADDR_FAN1_SEL: rd_cfg_q <= fan1_sel_q;
        default:            rd_cfg_q <= 8'h00;
      endcase
      reg_rvalid_o <= rd_q;
      if (rd_q) begin
        reg_rdata_o <= rd_mem_q ? mem_rdata[9:2] : rd_cfg_q;
      end
    end
  end

endmodule

// >>> tb/acs_seq_sva.sv
// acs_seq_sva.sv: port-level assertions for the conversion sequencer
// assumes one clock domain and the asynchronous active-low reset
`timescale 1ns/1ps
module acs_seq_sva #(
  parameter integer VOLT_CYC = 87500
) (
  input wire        clock_i,
  input wire        rst_n_i,
  input wire [7:0]  reg_addr_i,
  input wire [7:0]  reg_wdata_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [7:0]  reg_rdata_o,
  input wire        reg_rvalid_o,
  input wire [2:0]  adc_channel_o,
  input wire        adc_start_o,
  input wire [4:0]  atten_bypass_o,
  input wire        adc_done_i,
  input wire [11:0] adc_raw_i,
  input wire [7:0]  first_fan_tachometer_min_high_o
);
  reg  [31:0] since_q;
  wire        unm;
  assign unm = !(reg_addr_i == 8'h10 || reg_addr_i == 8'h55 || reg_addr_i == 8'h73 || reg_addr_i == 8'h7D
                 || reg_addr_i[7:3] == 5'h04);
  // cycles since the last slot start
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) since_q <= 32'h0000_0000;
    else if (adc_start_o) since_q <= 32'h0000_0001;
    else since_q <= since_q + 32'h0000_0001;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd_unm;
    reg_rd_i && unm ##2 reg_rvalid_o;
  endsequence
  sequence s_wr_all;
    reg_wr_i && reg_addr_i == 8'h73 && reg_wdata_i[5];
  endsequence
  rvalid_lat_a: assert property (reg_rd_i |-> ##2 reg_rvalid_o) else $error("read answer late");
  rvalid_src_a: assert property (reg_rvalid_o |-> $past(reg_rd_i, 2)) else $error("stray read answer");
  unmapped_rd_a: assert property (s_rd_unm |-> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  fan_share_a: assert property (reg_wr_i && reg_addr_i == 8'h55 |=>
    first_fan_tachometer_min_high_o == $past(reg_wdata_i)) else $error("fan limit byte not updated");
  bypass_all_a: assert property (s_wr_all |-> ##2 atten_bypass_o == 5'h1F) else $error("bypass all missing");
  chan_hold_a: assert property ($changed(adc_channel_o) |-> adc_start_o) else $error("channel moved mid slot");
  start_pulse_a: assert property (adc_start_o |=> !adc_start_o) else $error("start pulse too long");
  volt_slot_a: assert property (adc_start_o && since_q != 0 && $past(adc_channel_o) < 3'h5
    |-> since_q == VOLT_CYC) else $error("voltage slot length wrong");
endmodule
bind acs_sequencer acs_seq_sva #(.VOLT_CYC(VOLT_CYC)) u_sva (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .adc_channel_o(adc_channel_o),
  .adc_start_o(adc_start_o), .atten_bypass_o(atten_bypass_o), .adc_done_i(adc_done_i), .adc_raw_i(adc_raw_i),
  .first_fan_tachometer_min_high_o(first_fan_tachometer_min_high_o));

// >>> tb/acs_conv_model.sv
// acs_conv_model.sv: converter front end answering each slot start
// assumes dly_i between 1 and VOLT_CYC-2 cycles
`timescale 1ns/1ps
module acs_conv_model (
  input  wire        clock_i,
  input  wire        start_i,
  input  wire        jit_i,
  input  wire [3:0]  dly_i,
  input  wire [11:0] code_i,
  output reg         done_o,
  output reg  [11:0] raw_o
);
  integer n = 0;
  integer cnt = 0;
  initial done_o = 1'b0;
  initial raw_o = 12'h000;
  always @(posedge clock_i) begin
    done_o <= 1'b0;
    if (start_i) cnt <= dly_i;
    else if (cnt > 0) cnt <= cnt - 1;
    // answers alternate in runs of eight between code and code plus two
    if (cnt == 1) begin
      done_o <= 1'b1;
      raw_o <= code_i + ((jit_i && n[3]) ? 12'h002 : 12'h000);
      n <= n + 1;
    end else raw_o <= ~raw_o;
  end
endmodule

// >>> tb/testbench.sv
// testbench.sv: self-checking bench for the conversion sequencer
// assumes shortened slot and pass parameters
`timescale 1ns/1ps
module testbench;
  reg         clock_i, rst_n_i, reg_wr_i, reg_rd_i, jit, mon, single, slow;
  reg  [7:0]  reg_addr_i, reg_wdata_i, d;
  reg  [7:0]  mem [0:7];
  reg  [11:0] code;
  reg  [3:0]  dly;
  reg  [2:0]  ch_prev;
  wire [7:0]  reg_rdata_o, fan_o;
  wire        reg_rvalid_o, adc_start_o, adc_done_i;
  wire [2:0]  adc_channel_o;
  wire [4:0]  atten_bypass_o;
  wire [11:0] adc_raw_i;
  integer     error_cnt, n_checks, seed, i, v, cyc, t_prev, t_pass, seen;
  acs_sequencer #(.VOLT_CYC(8), .REMOTE_CYC(20), .LOCAL_CYC(12), .CYCLE_DEF(400), .CYCLE_SLOW(600)) uut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .adc_channel_o(adc_channel_o), .adc_start_o(adc_start_o), .atten_bypass_o(atten_bypass_o),
    .adc_done_i(adc_done_i), .adc_raw_i(adc_raw_i), .first_fan_tachometer_min_high_o(fan_o));
  acs_conv_model u_conv (.clock_i(clock_i), .start_i(adc_start_o), .jit_i(jit), .dly_i(dly), .code_i(code),
    .done_o(adc_done_i), .raw_o(adc_raw_i));
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk_b(input string nm, input [7:0] e, input [7:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_n(input string nm, input integer e, input integer g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task wr(input [7:0] a, input [7:0] dv);
    reg_addr_i = a;
    reg_wdata_i = dv;
    reg_wr_i = 1'b1;
    tick(1);
    reg_wr_i = 1'b0;
    tick(1);
  endtask
  task rd(input [7:0] a, output [7:0] q);
    integer k;
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    tick(1);
    reg_rd_i = 1'b0;
    for (k = 0; k < 4 && reg_rvalid_o !== 1'b1; k = k + 1) tick(1);
    if (k == 4) begin
      error_cnt = error_cnt + 1;
      $display("ERROR rvalid expected 1 seen 0");
      end_sim;
    end
    q = reg_rdata_o;
    tick(1);
  endtask
  task rd_all;
    integer j;
    for (j = 0; j < 8; j = j + 1) begin
      rd(8'h20 + j[7:0], d);
      chk_b("value", mem[j], d);
    end
  endtask
  function integer sl(input [2:0] c);
    sl = (c < 5) ? 8 : ((c == 6) ? 12 : 20);
  endfunction
  // slot and pass spacing watcher
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (!mon) seen = 0;
    else if (adc_start_o) begin
      if (seen > 0 && (single || ch_prev != 3'h7)) chk_n("slot", single ? 8 : sl(ch_prev), cyc - t_prev);
      if (!single && adc_channel_o == 3'h0) begin
        if (seen > 8) chk_n("pass", slow ? 600 : 400, cyc - t_pass);
        t_pass = cyc;
      end
      seen = seen + 1;
      t_prev = cyc;
      ch_prev = adc_channel_o;
    end
  end
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  initial begin
    seed = 32'h5775_2c78;
    {error_cnt, n_checks, cyc, seen, mon, single, slow, reg_wr_i, reg_rd_i, rst_n_i} = 0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    v = {$random(seed)} % 1000;
    code = v[11:0];
    jit = 1'b1;
    dly = 4'h6;
    for (i = 0; i < 8; i = i + 1) mem[i] = 8'h00;
    repeat (5) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    rd_all;
    for (i = 0; i < 5; i = i + 1) begin
      rd(8'h30 >> (i * 8), d);
      rd(40'h10_5573_7D30 >> (i * 8), d);
      chk_b("config", 8'h00, d);
    end
    $display("test reset done");
    for (i = 0; i < 8; i = i + 1) mem[i] = 8'((v + 1) >> 2);
    tick(1600);
    rd_all;
    $display("test averaging done");
    jit = 1'b0;
    dly = 4'h1;
    wr(8'h73, 8'h10);
    for (i = 0; i < 3; i = i + 1) begin
      code = (i == 0) ? 12'h300 : ((i == 1) ? 12'h800 : 12'h400);
      for (v = 0; v < 8; v = v + 1) mem[v] = (i == 0) ? 8'hC0 : ((i == 1) ? 8'h00 : 8'hFF);
      mon = (i > 0);
      tick(600);
      mon = 1'b0;
      rd_all;
    end
    wr(8'h10, 8'h80);
    slow = 1'b1;
    tick(700);
    mon = 1'b1;
    tick(1300);
    mon = 1'b0;
    $display("test single conversions done");
    for (i = 0; i < 32; i = i + 1) begin
      wr(8'h73, {2'b00, i[4], 5'h10});
      wr(8'h7D, {i[3:0], 4'h0});
      chk_b("bypass", i[4] ? 8'h1F : {3'b000, i[3], i[2], 1'b0, i[1], i[0]}, {3'b000, atten_bypass_o});
      rd(8'h7D, d);
      chk_b("cfg4", {i[3:0], 4'h0}, d);
    end
    $display("test bypass done");
    wr(8'h73, 8'h50);
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'h55, {i[2:0], 5'h13});
      chk_b("fan", {i[2:0], 5'h13}, fan_o);
      tick((i == 0) ? 500 : 10);
      code = 12'(i * 100 + 7);
      mem[i] = 8'((i * 100 + 7) >> 2);
      single = 1'b1;
      mon = 1'b1;
      tick(30);
      mon = 1'b0;
      chk_b("channel", {5'b00000, i[2:0]}, {5'b00000, adc_channel_o});
      rd_all;
    end
    $display("test single channel done");
    end_sim;
  end
endmodule
